// ===== pmc_pkg.sv
// shared constants and types of the power mode controller
package pmc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam int CTRL_W = 10;
  localparam int CTRL_RUN_LP = 0;
  localparam int CTRL_DEEP = 1;
  localparam int CTRL_STOP_LSB = 2;
  localparam int STOP_SEL_W = 2;
  localparam int CTRL_CLK_EXT = 4;
  localparam int CTRL_TPM_KEEP = 5;
  localparam int CTRL_UART_KEEP = 6;
  localparam int CTRL_RADIO_LSB = 7;
  localparam int RADIO_W = 3;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_FLAG = 4;
  localparam logic [1:0] STOP_NORMAL = 2'h0;
  localparam logic [1:0] STOP_LL = 2'h1;
  localparam logic [1:0] STOP_VLL3 = 2'h2;
  localparam logic [1:0] STOP_VLL1 = 2'h3;
  localparam int MODE_W = 4;
  localparam logic [3:0] MODE_RUN = 4'h0;
  localparam logic [3:0] MODE_WAIT = 4'h1;
  localparam logic [3:0] MODE_STOP = 4'h2;
  localparam logic [3:0] MODE_LP_RUN = 4'h3;
  localparam logic [3:0] MODE_LP_WAIT = 4'h4;
  localparam logic [3:0] MODE_LP_STOP = 4'h5;
  localparam logic [3:0] MODE_LL_STOP = 4'h6;
  localparam logic [3:0] MODE_VLL3 = 4'h7;
  localparam logic [3:0] MODE_VLL1 = 4'h8;
  localparam int MODE_COUNT = 9;
  localparam logic [1:0] CLK_NORMAL = 2'h0;
  localparam logic [1:0] CLK_INT = 2'h1;
  localparam logic [1:0] CLK_EXT = 2'h2;
  localparam int INT_OSC_KHZ = 4000;
  localparam int BUS_LIMIT_KHZ = 800;
  localparam int FLASH_SLOW_KHZ = 1000;
  localparam int BUS_DIV_W = 4;
  localparam logic [3:0] BUS_DIV_NORMAL = 4'h1;
  localparam int WAKE_W = 2;
  localparam int WAKE_ASYNC_WAKEUP_IRQ_CONTROLLER = 0;
  localparam int WAKE_LOW_LEAKAGE_WAKEUP_UNIT = 1;

  typedef enum logic [3:0] {
    S_RUN, S_WAIT, S_STOP, S_LP_RUN, S_LP_WAIT, S_LP_STOP,
    S_LL_STOP, S_LL_EXIT, S_VLL3, S_VLL1
  } pmc_state_e;
endpackage

// ===== pmc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pmc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  import pmc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } pmc_sync_s;

  pmc_sync_s cur;
  pmc_sync_s next_cur;

  generate
    if (WIDTH < 1) begin : g_bad
      $error("pmc_sync width must be at least one");
    end
  endgenerate

  // s1 feeds s2 only; the filter looks at s2 and s3
  always_comb begin
    next_cur = cur;
    next_cur.s1 = din;
    next_cur.s2 = cur.s1;
    next_cur.s3 = cur.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (cur.s2[i] == cur.s3[i]) begin
        next_cur.q[i] = cur.s2[i];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign dout = cur.q;
endmodule

// ===== pmc_regs.sv
// software register port: control word and status readback
`timescale 1ns/10ps
module pmc_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmc_pkg::DATA_W-1:0] reg_rdata,
  output logic [pmc_pkg::CTRL_W-1:0] ctrl,
  input wire logic [pmc_pkg::MODE_W-1:0] mode,
  input wire logic low_leakage_wakeup_unit_flag
);
  import pmc_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [DATA_W-1:0] rdata;
  } pmc_regs_s;

  pmc_regs_s cur;
  pmc_regs_s next_cur;
  logic [DATA_W-1:0] status_word;

  assign status_word = DATA_W'({low_leakage_wakeup_unit_flag, mode});

  // read data stand one cycle only; unmapped reads give zero
  always_comb begin
    next_cur = cur;
    next_cur.rdata = '0;
    if (reg_wr && reg_addr == OFS_CTRL) begin
      next_cur.ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (reg_rd) begin
      if (reg_addr == OFS_CTRL) begin
        next_cur.rdata = DATA_W'(cur.ctrl);
      end else if (reg_addr == OFS_STATUS) begin
        next_cur.rdata = status_word;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur <= '{ctrl: CTRL_RESET, rdata: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign ctrl = cur.ctrl;
endmodule

// ===== pmc_ctrl.sv
// power mode sequencer: mode state machine, clock gating, wake selection
//
// Operation
// - nine operating modes: run, wait and stop in normal and low-power forms
// - reset lands in normal run with regulator at full power
// - any reset returns from any low-power mode to normal run
// - each run mode has its own matching wait and stop mode
// - the wait-for-interrupt instruction triggers wait or stop entry
// - normal wait: core sleeps, peripherals clocked, interrupt wakes to run
// - normal stop keeps all registers and low-voltage detection
// - normal and low-power stop: peripheral clocks off, async wake controller wakes
// - low-power run: slow flash access, low-voltage detection off
// - internal bypass: fast internal oscillator, bus and flash below limit
// - low-power run may use external bypass clock instead
// - low-power wait: core asleep, fast clock on, interrupts accepted
// - low-power stop: detection off, converter and pin interrupts work
// - low-power stop: timer and serial clocks only if enabled and sourced
// - low-power stop: fast clock off, interrupt controller off, regulator low
// - low-power and leakage stop retain memory and hold pins
// - leakage stop: peripherals retained clock-stopped, wake unit wakes
// - leakage stop exits via wake unit interrupt service, not reset
// - pin states held in every low-power mode; the code holds them in every mode except normal run and low-power run
// - radio mode chosen independently of processor power mode
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module pmc_ctrl #(
  parameter int OSC_KHZ = pmc_pkg::INT_OSC_KHZ
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [pmc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic wfi_exec,
  input wire logic irq_pending,
  input wire logic async_wakeup_irq_controller_wake_pin,
  input wire logic low_leakage_wakeup_unit_wake_pin,
  input wire logic low_leakage_wakeup_unit_irq_ack,
  input wire logic tpm_src_en,
  input wire logic uart_src_en,
  output logic [pmc_pkg::MODE_W-1:0] power_mode,
  output logic core_sleep,
  output logic sleep_deep,
  output logic periph_clk_en,
  output logic fast_clk_en,
  output logic nested_irq_controller_en,
  output logic async_wakeup_irq_controller_en,
  output logic low_leakage_wakeup_unit_en,
  output logic lvd_en,
  output logic regulator_lp,
  output logic flash_slow,
  output logic [1:0] clk_src,
  output logic [pmc_pkg::BUS_DIV_W-1:0] bus_div,
  output logic tpm_clk_en,
  output logic uart_clk_en,
  output logic adc_irq_en,
  output logic reg_retain,
  output logic sram_power,
  output logic sram_retain,
  output logic io_hold,
  output logic low_leakage_wakeup_unit_irq,
  output logic wake_reset_req,
  output logic [pmc_pkg::RADIO_W-1:0] radio_mode
);
  import pmc_pkg::*;

  // divider so the internal oscillator lands strictly below the bus limit
  localparam int DIV_INT = OSC_KHZ / BUS_LIMIT_KHZ + 1;
  localparam logic [BUS_DIV_W-1:0] BUS_DIV_INT = BUS_DIV_W'(DIV_INT);

  generate
    if (DIV_INT >= (1 << BUS_DIV_W) || OSC_KHZ < 1) begin : g_bad_div
      $error("pmc_ctrl oscillator rate needs a divider wider than the bus divider field");
    end
  endgenerate

  typedef struct packed {
    pmc_state_e st;
    logic low_leakage_wakeup_unit_flag;
    logic wake_req;
  } pmc_ctl_s;

  pmc_ctl_s cur;
  pmc_ctl_s next_cur;
  logic [CTRL_W-1:0] ctrl;
  logic [WAKE_W-1:0] wake_raw;
  logic [WAKE_W-1:0] wake_sync;
  logic async_wakeup_irq_controller_w;
  logic low_leakage_wakeup_unit_w;
  logic run_lp;
  logic deep;
  logic [STOP_SEL_W-1:0] stop_sel;
  logic clk_ext;
  logic tpm_keep;
  logic uart_keep;
  logic lp_run_clk;

  function automatic logic is_deep(input pmc_state_e s);
    return s == S_STOP || s == S_LP_STOP || s == S_LL_STOP || s == S_VLL3 || s == S_VLL1;
  endfunction

  function automatic logic is_leak(input pmc_state_e s);
    return s == S_LL_STOP || s == S_VLL3 || s == S_VLL1;
  endfunction

  function automatic logic [MODE_W-1:0] mode_code(input pmc_state_e s);
    case (s)
      S_WAIT: return MODE_WAIT;
      S_STOP: return MODE_STOP;
      S_LP_RUN: return MODE_LP_RUN;
      S_LP_WAIT: return MODE_LP_WAIT;
      S_LP_STOP: return MODE_LP_STOP;
      S_LL_STOP: return MODE_LL_STOP;
      S_VLL3: return MODE_VLL3;
      S_VLL1: return MODE_VLL1;
      default: return MODE_RUN;
    endcase
  endfunction

  assign wake_raw[WAKE_ASYNC_WAKEUP_IRQ_CONTROLLER] = async_wakeup_irq_controller_wake_pin;
  assign wake_raw[WAKE_LOW_LEAKAGE_WAKEUP_UNIT] = low_leakage_wakeup_unit_wake_pin;

  pmc_sync #(
    .WIDTH(WAKE_W)
  ) u_pmc_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .din(wake_raw),
    .dout(wake_sync)
  );

  pmc_regs u_pmc_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ctrl(ctrl),
    .mode(power_mode),
    .low_leakage_wakeup_unit_flag(cur.low_leakage_wakeup_unit_flag)
  );

  assign async_wakeup_irq_controller_w = wake_sync[WAKE_ASYNC_WAKEUP_IRQ_CONTROLLER];
  assign low_leakage_wakeup_unit_w = wake_sync[WAKE_LOW_LEAKAGE_WAKEUP_UNIT];
  assign run_lp = ctrl[CTRL_RUN_LP];
  assign deep = ctrl[CTRL_DEEP];
  assign stop_sel = ctrl[CTRL_STOP_LSB +: STOP_SEL_W];
  assign clk_ext = ctrl[CTRL_CLK_EXT];
  assign tpm_keep = ctrl[CTRL_TPM_KEEP];
  assign uart_keep = ctrl[CTRL_UART_KEEP];

  always_comb begin
    next_cur = cur;
    case (cur.st)
      S_RUN: begin
        if (wfi_exec && !deep) begin
          next_cur.st = S_WAIT;
        end else if (wfi_exec) begin
          case (stop_sel)
            STOP_LL: next_cur.st = S_LL_STOP;
            STOP_VLL3: next_cur.st = S_VLL3;
            STOP_VLL1: next_cur.st = S_VLL1;
            default: next_cur.st = S_STOP;
          endcase
        end else if (run_lp) begin
          next_cur.st = S_LP_RUN;
        end
      end
      S_LP_RUN: begin
        // low-power run only offers its own wait and stop
        if (wfi_exec) begin
          next_cur.st = deep ? S_LP_STOP : S_LP_WAIT;
        end else if (!run_lp) begin
          next_cur.st = S_RUN;
        end
      end
      S_WAIT: begin
        if (irq_pending) begin
          next_cur.st = S_RUN;
        end
      end
      S_LP_WAIT: begin
        if (irq_pending) begin
          next_cur.st = S_LP_RUN;
        end
      end
      S_STOP: begin
        if (async_wakeup_irq_controller_w) begin
          next_cur.st = S_RUN;
        end
      end
      S_LP_STOP: begin
        if (async_wakeup_irq_controller_w) begin
          next_cur.st = S_LP_RUN;
        end
      end
      S_LL_STOP: begin
        if (low_leakage_wakeup_unit_w) begin
          next_cur.st = S_LL_EXIT;
        end
      end
      S_LL_EXIT: begin
        // a masked wake interrupt would park the chip here
        if (cur.low_leakage_wakeup_unit_flag && low_leakage_wakeup_unit_irq_ack) begin
          next_cur.st = S_RUN;
        end
      end
      S_VLL3, S_VLL1: begin
        // only a reset leaves these; the request asks for one
        if (low_leakage_wakeup_unit_w) begin
          next_cur.wake_req = 1'b1;
        end
      end
      default: next_cur.st = S_RUN;
    endcase
    // set wins over the acknowledge
    next_cur.low_leakage_wakeup_unit_flag = (cur.low_leakage_wakeup_unit_flag && !low_leakage_wakeup_unit_irq_ack) || (cur.st == S_LL_STOP && low_leakage_wakeup_unit_w);
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur <= '{st: S_RUN, low_leakage_wakeup_unit_flag: 1'b0, wake_req: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign lp_run_clk = cur.st == S_LP_RUN || cur.st == S_LP_WAIT;

  assign power_mode = mode_code(cur.st);
  assign core_sleep = !(cur.st == S_RUN || cur.st == S_LP_RUN || cur.st == S_LL_EXIT);
  assign sleep_deep = is_deep(cur.st);
  assign periph_clk_en = !is_deep(cur.st);
  assign fast_clk_en = !is_deep(cur.st);
  assign nested_irq_controller_en = !is_deep(cur.st);
  assign async_wakeup_irq_controller_en = cur.st == S_STOP || cur.st == S_LP_STOP;
  assign low_leakage_wakeup_unit_en = is_leak(cur.st);
  assign lvd_en = cur.st == S_RUN || cur.st == S_WAIT || cur.st == S_STOP || cur.st == S_LL_EXIT;
  assign regulator_lp = lp_run_clk || cur.st == S_LP_STOP || is_leak(cur.st);
  assign flash_slow = lp_run_clk;
  assign clk_src = lp_run_clk ? (clk_ext ? CLK_EXT : CLK_INT) : CLK_NORMAL;
  // external bypass rate is the user's; only the internal source is divided here
  assign bus_div = (lp_run_clk && !clk_ext) ? BUS_DIV_INT : BUS_DIV_NORMAL;
  assign tpm_clk_en = is_deep(cur.st) ? (cur.st == S_LP_STOP && tpm_keep && tpm_src_en) : 1'b1;
  assign uart_clk_en = is_deep(cur.st) ? (cur.st == S_LP_STOP && uart_keep && uart_src_en) : 1'b1;
  assign adc_irq_en = !is_leak(cur.st);
  assign reg_retain = !(cur.st == S_VLL3 || cur.st == S_VLL1);
  assign sram_power = cur.st != S_VLL1;
  assign sram_retain = cur.st == S_LP_STOP || cur.st == S_LL_STOP || cur.st == S_VLL3;
  assign io_hold = !(cur.st == S_RUN || cur.st == S_LP_RUN);
  assign low_leakage_wakeup_unit_irq = cur.low_leakage_wakeup_unit_flag;
  assign wake_reset_req = cur.wake_req;
  assign radio_mode = ctrl[CTRL_RADIO_LSB +: RADIO_W];

  sequence s_run_wfi;
    power_mode == MODE_RUN && wfi_exec;
  endsequence

  sequence s_ll_wake;
    power_mode == MODE_LL_STOP && low_leakage_wakeup_unit_w;
  endsequence

  a_reset_run: assert property (@(posedge ref_clk) $fell(reset) |-> power_mode == MODE_RUN && !regulator_lp)
    else $error("not in full-power run after reset");

  a_mode_range: assert property (@(posedge ref_clk) disable iff (reset) power_mode < MODE_W'(MODE_COUNT))
    else $error("mode code outside the nine modes");

  a_wait_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_run_wfi ##0 !deep |=> power_mode == MODE_WAIT && core_sleep && periph_clk_en)
    else $error("wait entry wrong");

  a_stop_entry: assert property (@(posedge ref_clk) disable iff (reset)
    s_run_wfi ##0 deep && stop_sel == STOP_NORMAL |=> power_mode == MODE_STOP && async_wakeup_irq_controller_en && !nested_irq_controller_en)
    else $error("stop entry wrong");

  a_lp_match: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_RUN && wfi_exec |=> power_mode == (deep ? MODE_LP_STOP : MODE_LP_WAIT))
    else $error("low-power run left for a foreign sleep mode");

  a_wait_wake: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_WAIT && irq_pending |=> power_mode == MODE_RUN && !core_sleep)
    else $error("interrupt did not wake wait");

  a_stop_regs: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_STOP |-> reg_retain && lvd_en && !periph_clk_en)
    else $error("normal stop lost retention or detection");

  a_lp_run_clk: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_RUN |-> flash_slow && !lvd_en && clk_src == (clk_ext ? CLK_EXT : CLK_INT))
    else $error("low-power run clocking wrong");

  a_bus_limit: assert property (@(posedge ref_clk) disable iff (reset)
    clk_src == CLK_INT |-> OSC_KHZ / int'(bus_div) < BUS_LIMIT_KHZ)
    else $error("bus clock not below limit");

  a_lp_wait_fast_system_clock: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_WAIT |-> fast_clk_en && nested_irq_controller_en && core_sleep && regulator_lp)
    else $error("low-power wait clocking wrong");

  a_lp_stop_off: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_STOP |-> !fast_clk_en && !nested_irq_controller_en && regulator_lp && !lvd_en && adc_irq_en)
    else $error("low-power stop clocking wrong");

  a_lp_stop_tpm: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_STOP |-> tpm_clk_en == (tpm_keep && tpm_src_en)
    && uart_clk_en == (uart_keep && uart_src_en))
    else $error("timer or serial clock gating wrong");

  a_retain_mem: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LP_STOP || power_mode == MODE_LL_STOP |-> sram_retain && sram_power && io_hold)
    else $error("memory or pins not retained");

  a_ll_units: assert property (@(posedge ref_clk) disable iff (reset)
    power_mode == MODE_LL_STOP |-> low_leakage_wakeup_unit_en && !nested_irq_controller_en && !periph_clk_en && !async_wakeup_irq_controller_en)
    else $error("leakage stop wake selection wrong");

  a_ll_exit: assert property (@(posedge ref_clk) disable iff (reset)
    s_ll_wake |=> low_leakage_wakeup_unit_irq && !core_sleep && !wake_reset_req && io_hold)
    else $error("leakage stop not left through wake interrupt");

  // flag must stay up until service, or the exit state is never left
  a_flag_hold: assert property (@(posedge ref_clk) disable iff (reset)
    low_leakage_wakeup_unit_irq && !low_leakage_wakeup_unit_irq_ack |=> low_leakage_wakeup_unit_irq)
    else $error("wake interrupt flag dropped before service");

  a_ll_ack: assert property (@(posedge ref_clk) disable iff (reset)
    low_leakage_wakeup_unit_irq && low_leakage_wakeup_unit_irq_ack && power_mode == MODE_RUN && !core_sleep |=> !low_leakage_wakeup_unit_irq && power_mode == MODE_RUN)
    else $error("wake interrupt service did not finish in run");

  a_pins_hold: assert property (@(posedge ref_clk) disable iff (reset)
    core_sleep |-> io_hold)
    else $error("pins released while asleep");

  a_radio_free: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(power_mode) && !$past(reg_wr) |-> $stable(radio_mode))
    else $error("radio mode followed processor mode");
endmodule

// ===== pmc_core_model.sv
// behavioural core, interrupt controller and wake sources
`timescale 1ns/10ps
module pmc_core_model (
  input wire logic ref_clk,
  input wire logic low_leakage_wakeup_unit_irq,
  output logic wfi_exec,
  output logic irq_pending,
  output logic async_wakeup_irq_controller_wake_pin,
  output logic low_leakage_wakeup_unit_wake_pin,
  output logic low_leakage_wakeup_unit_irq_ack,
  output logic tpm_src_en,
  output logic uart_src_en
);
  initial begin
    wfi_exec = 1'h0;
    irq_pending = 1'h0;
    async_wakeup_irq_controller_wake_pin = 1'h0;
    low_leakage_wakeup_unit_wake_pin = 1'h0;
    low_leakage_wakeup_unit_irq_ack = 1'h0;
    tpm_src_en = 1'h1;
    uart_src_en = 1'h1;
  end
  task automatic wait_for_interrupt_instr();
    @(posedge ref_clk);
    wfi_exec <= 1'h1;
    @(posedge ref_clk);
    wfi_exec <= 1'h0;
  endtask
  // level held n cycles, then back to idle
  task automatic irq(input int n);
    @(posedge ref_clk);
    irq_pending <= 1'h1;
    repeat (n) @(posedge ref_clk);
    irq_pending <= 1'h0;
  endtask
  task automatic wake(input logic ll, input int n);
    @(posedge ref_clk);
    if (ll) low_leakage_wakeup_unit_wake_pin <= 1'h1;
    else async_wakeup_irq_controller_wake_pin <= 1'h1;
    repeat (n) @(posedge ref_clk);
    low_leakage_wakeup_unit_wake_pin <= 1'h0;
    async_wakeup_irq_controller_wake_pin <= 1'h0;
  endtask
  // wake interrupt never masked, else leakage exit would hang
  task automatic service();
    @(posedge ref_clk);
    low_leakage_wakeup_unit_irq_ack <= low_leakage_wakeup_unit_irq;
    @(posedge ref_clk);
    low_leakage_wakeup_unit_irq_ack <= 1'h0;
  endtask
  task automatic src(input logic t, input logic u);
    @(posedge ref_clk);
    tpm_src_en <= t;
    uart_src_en <= u;
  endtask
endmodule

// ===== pmc_ctrl_tb.sv
// self-checking testbench of the power mode controller
`timescale 1ns/10ps
module pmc_ctrl_tb;
  import pmc_pkg::*;
  logic ref_clk;
  logic reset;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic wfi_exec, irq_pending, async_wakeup_irq_controller_wake_pin, low_leakage_wakeup_unit_wake_pin, low_leakage_wakeup_unit_irq_ack, tpm_src_en, uart_src_en;
  logic [MODE_W-1:0] power_mode;
  logic core_sleep, sleep_deep, periph_clk_en, fast_clk_en, nested_irq_controller_en, async_wakeup_irq_controller_en, low_leakage_wakeup_unit_en, lvd_en;
  logic regulator_lp, flash_slow, tpm_clk_en, uart_clk_en, adc_irq_en, reg_retain, sram_power;
  logic sram_retain, io_hold, low_leakage_wakeup_unit_irq, wake_reset_req;
  logic [1:0] clk_src;
  logic [BUS_DIV_W-1:0] bus_div;
  logic [RADIO_W-1:0] radio_mode;
  logic [13:0] lv;
  int n_mismatch;
  int n_checks;
  int d;
  assign lv = {core_sleep, sleep_deep, periph_clk_en, fast_clk_en, nested_irq_controller_en, async_wakeup_irq_controller_en, low_leakage_wakeup_unit_en,
    lvd_en, regulator_lp, flash_slow, adc_irq_en, reg_retain, sram_retain, io_hold};
  pmc_ctrl #(.OSC_KHZ(INT_OSC_KHZ)) u_pmc_ctrl (
    .ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wfi_exec,
    .irq_pending, .async_wakeup_irq_controller_wake_pin, .low_leakage_wakeup_unit_wake_pin, .low_leakage_wakeup_unit_irq_ack, .tpm_src_en, .uart_src_en,
    .power_mode, .core_sleep, .sleep_deep, .periph_clk_en, .fast_clk_en, .nested_irq_controller_en, .async_wakeup_irq_controller_en,
    .low_leakage_wakeup_unit_en, .lvd_en, .regulator_lp, .flash_slow, .clk_src, .bus_div, .tpm_clk_en,
    .uart_clk_en, .adc_irq_en, .reg_retain, .sram_power, .sram_retain, .io_hold, .low_leakage_wakeup_unit_irq,
    .wake_reset_req, .radio_mode
  );
  pmc_core_model u_pmc_core_model (
    .ref_clk, .low_leakage_wakeup_unit_irq, .wfi_exec, .irq_pending, .async_wakeup_irq_controller_wake_pin, .low_leakage_wakeup_unit_wake_pin,
    .low_leakage_wakeup_unit_irq_ack, .tpm_src_en, .uart_src_en
  );
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic lvl(input string nm, input logic [13:0] e, input logic [13:0] m);
    chk(nm, {18'h0, e & m}, {18'h0, lv & m});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic wait_mode(input logic [3:0] e, input int n);
    #1;
    for (int i = 0; i < n && power_mode !== e; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("power_mode", {28'h0, e}, {28'h0, power_mode});
  endtask
  task automatic rst();
    @(posedge ref_clk);
    reset <= 1'h1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
  endtask
  function automatic logic [31:0] cw(input logic lp, input logic dp, input logic [1:0] sel, input logic ext);
    cw = 32'h0;
    cw[CTRL_RUN_LP] = lp;
    cw[CTRL_DEEP] = dp;
    cw[CTRL_STOP_LSB +: STOP_SEL_W] = sel;
    cw[CTRL_CLK_EXT] = ext;
    cw[CTRL_TPM_KEEP] = 1'h1;
    cw[CTRL_RADIO_LSB +: RADIO_W] = 3'h5;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    reset = 1'h1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    lvl("run", 14'h0E4C, 14'h3FFF);
    chk("bus_div", {28'h0, BUS_DIV_NORMAL}, {28'h0, bus_div});
    rd("ctrl", OFS_CTRL, 32'h0);
    wr(OFS_STATUS, 32'h1F);
    rd("status", OFS_STATUS, 32'h0);
    rd("unmapped", 8'h40, 32'h0);
    wr(OFS_CTRL, cw(1'h0, 1'h0, STOP_NORMAL, 1'h0));
    #1 chk("radio", 32'h5, {29'h0, radio_mode});
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_WAIT, 3);
    lvl("wait", 14'h2E01, 14'h3E01);
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_WAIT, 1);
    u_pmc_core_model.irq(2);
    wait_mode(MODE_RUN, 3);
    wr(OFS_CTRL, cw(1'h0, 1'h1, STOP_NORMAL, 1'h0));
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_STOP, 3);
    lvl("stop", 14'h3145, 14'h3B45);
    u_pmc_core_model.irq(3);
    wait_mode(MODE_STOP, 1);
    u_pmc_core_model.wake(1'h0, 6);
    wait_mode(MODE_RUN, 8);
    for (d = 1; d < 15 && INT_OSC_KHZ / d >= BUS_LIMIT_KHZ; d++) begin
    end
    wr(OFS_CTRL, cw(1'h1, 1'h0, STOP_NORMAL, 1'h0));
    wait_mode(MODE_LP_RUN, 3);
    lvl("lp run", 14'h0830, 14'h2870);
    chk("clk_src", {30'h0, CLK_INT}, {30'h0, clk_src});
    chk("bus_div", d, {28'h0, bus_div});
    wr(OFS_CTRL, cw(1'h1, 1'h0, STOP_NORMAL, 1'h1));
    repeat (2) @(posedge ref_clk);
    #1 chk("clk_src", {30'h0, CLK_EXT}, {30'h0, clk_src});
    wr(OFS_CTRL, cw(1'h1, 1'h0, STOP_NORMAL, 1'h0));
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_LP_WAIT, 3);
    lvl("lp wait", 14'h2630, 14'h2670);
    u_pmc_core_model.irq(2);
    wait_mode(MODE_LP_RUN, 3);
    wr(OFS_CTRL, cw(1'h1, 1'h1, STOP_NORMAL, 1'h0));
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_LP_STOP, 3);
    lvl("lp stop", 14'h312B, 14'h3F6B);
    chk("sram_power", 32'h1, {31'h0, sram_power});
    chk("tpm clk", 32'h1, {31'h0, tpm_clk_en});
    chk("uart clk", 32'h0, {31'h0, uart_clk_en});
    u_pmc_core_model.src(1'h0, 1'h1);
    repeat (2) @(posedge ref_clk);
    #1 chk("tpm clk", 32'h0, {31'h0, tpm_clk_en});
    u_pmc_core_model.wake(1'h0, 6);
    wait_mode(MODE_LP_RUN, 8);
    u_pmc_core_model.src(1'h1, 1'h1);
    wr(OFS_CTRL, cw(1'h0, 1'h1, STOP_LL, 1'h0));
    wait_mode(MODE_RUN, 3);
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_LL_STOP, 3);
    lvl("ll stop", 14'h3083, 14'h3AC3);
    chk("radio", 32'h5, {29'h0, radio_mode});
    u_pmc_core_model.wake(1'h1, 6);
    repeat (6) @(posedge ref_clk);
    #1 chk("low_leakage_wakeup_unit_irq", 32'h1, {31'h0, low_leakage_wakeup_unit_irq});
    lvl("ll exit", 14'h0001, 14'h2001);
    wait_mode(MODE_RUN, 1);
    rd("status flag", OFS_STATUS, 32'h10);
    u_pmc_core_model.service();
    #1 lvl("ll done", 14'h0000, 14'h2001);
    chk("low_leakage_wakeup_unit_irq", 32'h0, {31'h0, low_leakage_wakeup_unit_irq});
    chk("reset req", 32'h0, {31'h0, wake_reset_req});
    wr(OFS_CTRL, cw(1'h0, 1'h1, STOP_VLL3, 1'h0));
    rd("ctrl", OFS_CTRL, cw(1'h0, 1'h1, STOP_VLL3, 1'h0));
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_VLL3, 3);
    lvl("vll3", 14'h30A3, 14'h3FFF);
    u_pmc_core_model.wake(1'h1, 6);
    repeat (2) @(posedge ref_clk);
    #1 chk("reset req", 32'h1, {31'h0, wake_reset_req});
    rst();
    wait_mode(MODE_RUN, 1);
    chk("reset req", 32'h0, {31'h0, wake_reset_req});
    rd("ctrl", OFS_CTRL, 32'h0);
    wr(OFS_CTRL, cw(1'h0, 1'h1, STOP_VLL1, 1'h0));
    u_pmc_core_model.wait_for_interrupt_instr();
    wait_mode(MODE_VLL1, 3);
    lvl("vll1", 14'h30A1, 14'h3FFF);
    chk("sram_power", 32'h0, {31'h0, sram_power});
    rst();
    wait_mode(MODE_RUN, 1);
    lvl("run", 14'h0E4C, 14'h3FFF);
    test_done();
  end
endmodule
